// File: sns_status_regs.svh
// register offsets, bit positions and reset values of the sensor status bank
`ifndef SNS_STATUS_REGS_SVH
`define SNS_STATUS_REGS_SVH

// ==========================================================================
// word offsets (byte addresses, one 16-bit word each)
`define SNS_OFS_CMD        8'h22
`define SNS_OFS_TEMP       8'h2e
`define SNS_OFS_PRES       8'h30
`define SNS_OFS_SYNC       8'h32
`define SNS_OFS_STATUS     8'h36
`define SNS_OFS_SER_LO     8'h50
`define SNS_OFS_SER_HI     8'h52
`define SNS_WORD_STEP      8'h02

// ==========================================================================
// status bit positions
`define SNS_BIT_IDLE       0
`define SNS_BIT_PRES_UP    3
`define SNS_BIT_TEMP_UP    4
`define SNS_BIT_SUPPLY     7
`define SNS_BIT_CHECK      8
`define SNS_BIT_SAT        10
`define SNS_BIT_CRC        11
`define SNS_BIT_PRES_MISS  14
`define SNS_BIT_TEMP_MISS  15

// ==========================================================================
// masks and reset values
`define SNS_EVENT_MASK     16'hc998
`define SNS_LIVE_MASK      16'h0401
`define SNS_SYNC_COPY_MASK 16'hffe1
`define SNS_CLEAR_ALL      16'hffff
`define SNS_STATUS_RESET   16'h0000
`define SNS_RESULT_RESET   16'h0000

`endif

// File: sns_pkg.sv
// types shared by the sensor status register bank
package sns_pkg;

	typedef enum logic [1:0] {
		SNS_ACC_NONE  = 2'b00,
		SNS_ACC_READ  = 2'b01,
		SNS_ACC_WRITE = 2'b10
	} sns_access_t;

	typedef logic [15:0] sns_word_t;

endpackage

// File: sns_event_flags.sv
// sticky event flag vector: set wins over clear in the same cycle
`timescale 1ns/1ps

module sns_event_flags #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] setVec,
	input  wire logic [WIDTH-1:0] clrVec,
	output logic      [WIDTH-1:0] flags
);

	logic [WIDTH-1:0] flags_reg;
	logic [WIDTH-1:0] flags_next;

	always_comb begin
		flags_next = (flags_reg & ~clrVec) | setVec;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags = flags_reg;

endmodule

// File: sns_status_regs.sv
// status, synchronized status, result and serial number registers of the sensor
`timescale 1ns/1ps
`include "sns_status_regs.svh"

module sns_status_regs #(
	parameter logic [63:0] SERIAL_NUMBER = 64'h0000_0000_5a5a_a5a5 // value arbitrary
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hostAddrLoad,
	input  wire logic [7:0]  hostAddr,
	input  wire logic        hostRead,
	input  wire logic        hostWrite,
	input  wire logic [15:0] hostWrData,
	input  wire logic        tempUpdate,
	input  wire logic [15:0] tempValue,
	input  wire logic        presUpdate,
	input  wire logic [15:0] presValue,
	input  wire logic        chipBusy,
	input  wire logic        dspSaturated,
	input  wire logic        bridgeSupplyFault,
	input  wire logic        bridgeCheckFault,
	input  wire logic        comCrcError,
	output logic [15:0]      hostRdData,
	output logic             hostRdValid,
	output logic             hostWrReject,
	output logic             cmdWrite,
	output logic [15:0]      cmdWord
);

	// ======================================================================
	// address pointer and access decode
	sns_pkg::sns_access_t access;
	logic [7:0]           effAddr;
	logic [7:0]           addr_reg;
	logic [7:0]           addr_next;
	logic                 tempRead;
	logic                 presRead;
	logic                 statusWrite;

	always_comb begin
		effAddr = hostAddrLoad ? hostAddr : addr_reg;
		if (hostRead) begin
			access = sns_pkg::SNS_ACC_READ;
		end else if (hostWrite) begin
			access = sns_pkg::SNS_ACC_WRITE;
		end else begin
			access = sns_pkg::SNS_ACC_NONE;
		end
		tempRead    = (access == sns_pkg::SNS_ACC_READ) && (effAddr == `SNS_OFS_TEMP);
		presRead    = (access == sns_pkg::SNS_ACC_READ) && (effAddr == `SNS_OFS_PRES);
		statusWrite = (access == sns_pkg::SNS_ACC_WRITE) && (effAddr == `SNS_OFS_STATUS);
	end

	always_comb begin
		addr_next = effAddr;
		if (access != sns_pkg::SNS_ACC_NONE) begin
			addr_next = effAddr + `SNS_WORD_STEP;
		end
	end

	// ======================================================================
	// measurement results and live conditions
	sns_pkg::sns_word_t tempResult_reg;
	sns_pkg::sns_word_t tempResult_next;
	sns_pkg::sns_word_t presResult_reg;
	sns_pkg::sns_word_t presResult_next;
	logic               idle_reg;
	logic               idle_next;
	logic               sat_reg;
	logic               sat_next;

	always_comb begin
		tempResult_next = tempUpdate ? tempValue : tempResult_reg;
		presResult_next = presUpdate ? presValue : presResult_reg;
		idle_next       = !chipBusy;
		sat_next        = dspSaturated;
	end

	// ======================================================================
	// sticky events
	logic [15:0] evtSet;
	logic [15:0] evtClr;
	logic [15:0] evtFlags;

	always_comb begin
		evtSet = 16'h0000;
		evtSet[`SNS_BIT_PRES_UP]   = presUpdate;
		evtSet[`SNS_BIT_TEMP_UP]   = tempUpdate;
		// an unread result being overwritten is judged on the flag before this edge
		evtSet[`SNS_BIT_PRES_MISS] = presUpdate && evtFlags[`SNS_BIT_PRES_UP];
		evtSet[`SNS_BIT_TEMP_MISS] = tempUpdate && evtFlags[`SNS_BIT_TEMP_UP];
		evtSet[`SNS_BIT_SUPPLY]    = bridgeSupplyFault;
		evtSet[`SNS_BIT_CHECK]     = bridgeCheckFault;
		evtSet[`SNS_BIT_CRC]       = comCrcError;
		evtClr = 16'h0000;
		if (statusWrite) begin
			evtClr = hostWrData & `SNS_EVENT_MASK;
		end
		evtClr[`SNS_BIT_PRES_UP] = evtClr[`SNS_BIT_PRES_UP] | presRead;
		evtClr[`SNS_BIT_TEMP_UP] = evtClr[`SNS_BIT_TEMP_UP] | tempRead;
	end

	sns_event_flags #(
		.WIDTH(16)
	) sns_event_flags_i (
		.clk   (clk),
		.rst_n (rst_n),
		.setVec(evtSet & `SNS_EVENT_MASK),
		.clrVec(evtClr),
		.flags (evtFlags)
	);

	// ======================================================================
	// main and synchronized status words
	sns_pkg::sns_word_t mainStatus;
	sns_pkg::sns_word_t syncStatus;
	logic [1:0]         syncUp_reg;
	logic [1:0]         syncUp_next;

	always_comb begin
		mainStatus = evtFlags & `SNS_EVENT_MASK;
		mainStatus[`SNS_BIT_IDLE] = idle_reg;
		mainStatus[`SNS_BIT_SAT]  = sat_reg;
		syncStatus = mainStatus & `SNS_SYNC_COPY_MASK;
		syncStatus[`SNS_BIT_PRES_UP] = syncUp_reg[0];
		syncStatus[`SNS_BIT_TEMP_UP] = syncUp_reg[1];
	end

	// captured before the read clears the main flag, so a burst sees the pair together
	always_comb begin
		syncUp_next = syncUp_reg;
		if (presRead) begin
			syncUp_next[0] = evtFlags[`SNS_BIT_PRES_UP];
		end
		if (tempRead) begin
			syncUp_next[1] = evtFlags[`SNS_BIT_TEMP_UP];
		end
	end

	// ======================================================================
	// host answers
	sns_pkg::sns_word_t rdData_reg;
	sns_pkg::sns_word_t rdData_next;
	logic               rdValid_reg;
	logic               rdValid_next;
	logic               wrReject_reg;
	logic               wrReject_next;
	logic               cmdWrite_reg;
	logic               cmdWrite_next;
	sns_pkg::sns_word_t cmdWord_reg;
	sns_pkg::sns_word_t cmdWord_next;

	always_comb begin
		rdData_next   = 16'h0000;
		rdValid_next  = 1'b0;
		wrReject_next = 1'b0;
		cmdWrite_next = 1'b0;
		cmdWord_next  = cmdWord_reg;
		unique case (access)
			sns_pkg::SNS_ACC_NONE: begin
			end
			sns_pkg::SNS_ACC_READ: begin
				rdValid_next = 1'b1;
				case (effAddr)
					`SNS_OFS_TEMP:   rdData_next = tempResult_reg;
					`SNS_OFS_PRES:   rdData_next = presResult_reg;
					`SNS_OFS_SYNC:   rdData_next = syncStatus;
					`SNS_OFS_STATUS: rdData_next = mainStatus;
					`SNS_OFS_SER_LO: rdData_next = SERIAL_NUMBER[15:0];
					`SNS_OFS_SER_HI: rdData_next = SERIAL_NUMBER[31:16];
					default:         rdData_next = 16'h0000;
				endcase
			end
			sns_pkg::SNS_ACC_WRITE: begin
				if (effAddr == `SNS_OFS_CMD) begin
					cmdWrite_next = 1'b1;
					cmdWord_next  = hostWrData;
				end else if (effAddr != `SNS_OFS_STATUS) begin
					// sync copy included: its event flags clear through main status, its update flags on result reads
					wrReject_next = 1'b1;
				end
			end
			default: begin
			end
		endcase
	end

	// ======================================================================
	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg       <= 8'h00;
			tempResult_reg <= `SNS_RESULT_RESET;
			presResult_reg <= `SNS_RESULT_RESET;
			idle_reg       <= 1'b0;
			sat_reg        <= 1'b0;
			syncUp_reg     <= 2'h0;
			rdData_reg     <= 16'h0000;
			rdValid_reg    <= 1'b0;
			wrReject_reg   <= 1'b0;
			cmdWrite_reg   <= 1'b0;
			cmdWord_reg    <= 16'h0000;
		end else begin
			addr_reg       <= addr_next;
			tempResult_reg <= tempResult_next;
			presResult_reg <= presResult_next;
			idle_reg       <= idle_next;
			sat_reg        <= sat_next;
			syncUp_reg     <= syncUp_next;
			rdData_reg     <= rdData_next;
			rdValid_reg    <= rdValid_next;
			wrReject_reg   <= wrReject_next;
			cmdWrite_reg   <= cmdWrite_next;
			cmdWord_reg    <= cmdWord_next;
		end
	end

	assign hostRdData   = rdData_reg;
	assign hostRdValid  = rdValid_reg;
	assign hostWrReject = wrReject_reg;
	assign cmdWrite     = cmdWrite_reg;
	assign cmdWord      = cmdWord_reg;

	// ======================================================================
	// checks
	a_idle_tracks: assert property (@(posedge clk) disable iff (!rst_n)
		chipBusy |=> !mainStatus[`SNS_BIT_IDLE] && !syncStatus[`SNS_BIT_IDLE])
		else $error("idle bit not low after busy");

	// status reads are checked for the idle bit; serial words may have bit 0 set
	a_idle_read: assert property (@(posedge clk) disable iff (!rst_n)
		chipBusy ##1 (hostRead && effAddr == `SNS_OFS_STATUS) |=> !hostRdData[`SNS_BIT_IDLE])
		else $error("status read shows idle while busy");

	a_pres_up_set: assert property (@(posedge clk) disable iff (!rst_n)
		presUpdate |=> evtFlags[`SNS_BIT_PRES_UP])
		else $error("pressure update flag not set");

	a_pres_up_clear: assert property (@(posedge clk) disable iff (!rst_n)
		presRead && !presUpdate |=> !evtFlags[`SNS_BIT_PRES_UP])
		else $error("pressure update flag not cleared by read");

	a_temp_up_flow: assert property (@(posedge clk) disable iff (!rst_n)
		tempUpdate |=> evtFlags[`SNS_BIT_TEMP_UP])
		else $error("temperature update flag not set");

	a_temp_up_clear: assert property (@(posedge clk) disable iff (!rst_n)
		tempRead && !tempUpdate |=> !evtFlags[`SNS_BIT_TEMP_UP])
		else $error("temperature update flag not cleared by read");

	a_pres_missed: assert property (@(posedge clk) disable iff (!rst_n)
		presUpdate && evtFlags[`SNS_BIT_PRES_UP] |=> evtFlags[`SNS_BIT_PRES_MISS])
		else $error("pressure overwrite not flagged");

	a_temp_missed: assert property (@(posedge clk) disable iff (!rst_n)
		tempUpdate && evtFlags[`SNS_BIT_TEMP_UP] |=> evtFlags[`SNS_BIT_TEMP_MISS])
		else $error("temperature overwrite not flagged");

	a_fault_events: assert property (@(posedge clk) disable iff (!rst_n)
		bridgeSupplyFault || bridgeCheckFault || comCrcError |=>
		(!$past(bridgeSupplyFault) || mainStatus[`SNS_BIT_SUPPLY])
		&& (!$past(bridgeCheckFault) || mainStatus[`SNS_BIT_CHECK])
		&& (!$past(comCrcError) || mainStatus[`SNS_BIT_CRC]))
		else $error("fault event lost");

	a_sat_live: assert property (@(posedge clk) disable iff (!rst_n)
		!dspSaturated |=> !mainStatus[`SNS_BIT_SAT])
		else $error("saturation bit held without its source");

	a_event_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		evtFlags[`SNS_BIT_CHECK] && !(statusWrite && hostWrData[`SNS_BIT_CHECK])
		|=> evtFlags[`SNS_BIT_CHECK] [*1] ##0 mainStatus[`SNS_BIT_CHECK])
		else $error("event flag dropped without a clearing write");

	a_clear_all: assert property (@(posedge clk) disable iff (!rst_n)
		statusWrite && hostWrData == `SNS_CLEAR_ALL && (evtSet & `SNS_EVENT_MASK) == 16'h0000
		|=> (mainStatus & `SNS_EVENT_MASK) == 16'h0000)
		else $error("clear-all write left an event set");

	a_sync_copy: assert property (@(posedge clk) disable iff (!rst_n)
		((syncStatus ^ mainStatus) & `SNS_SYNC_COPY_MASK) == 16'h0000
		&& (mainStatus & ~(`SNS_EVENT_MASK | `SNS_LIVE_MASK)) == 16'h0000)
		else $error("sync copy differs or reserved bit set");

	a_sync_capture: assert property (@(posedge clk) disable iff (!rst_n)
		tempRead |=> syncStatus[`SNS_BIT_TEMP_UP] == $past(evtFlags[`SNS_BIT_TEMP_UP]))
		else $error("sync temperature flag not captured");

	a_burst_temp: assert property (@(posedge clk) disable iff (!rst_n)
		tempRead ##1 hostRead && !hostAddrLoad |=> hostRdValid && addr_reg == `SNS_OFS_SYNC)
		else $error("burst did not advance past pressure");

	a_serial_read: assert property (@(posedge clk) disable iff (!rst_n)
		hostRead && effAddr == `SNS_OFS_SER_LO |=> hostRdData == SERIAL_NUMBER[15:0])
		else $error("serial low word wrong");

	a_write_reject: assert property (@(posedge clk) disable iff (!rst_n)
		access == sns_pkg::SNS_ACC_WRITE && effAddr == `SNS_OFS_SYNC
		|=> hostWrReject && $stable(syncUp_reg))
		else $error("write to sync copy not rejected");

	a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		bridgeSupplyFault && statusWrite && hostWrData[`SNS_BIT_SUPPLY]
		|=> mainStatus[`SNS_BIT_SUPPLY])
		else $error("event lost to simultaneous clear");

endmodule

// File: sns_host_model.sv
// host model: word reads and writes on the register port of the status bank
`timescale 1ns/1ps

module sns_host_model (
	input  wire logic        clk,
	output logic             hostAddrLoad,
	output logic [7:0]       hostAddr,
	output logic             hostRead,
	output logic             hostWrite,
	output logic [15:0]      hostWrData,
	input  wire logic [15:0] hostRdData,
	input  wire logic        hostRdValid,
	input  wire logic        hostWrReject
);
	sns_pkg::sns_word_t got [0:2];
	logic               gotValid [0:2];
	logic               gotRej;

	initial begin
		hostAddrLoad = 1'b0;
		hostAddr = 8'h00;
		hostRead = 1'b0;
		hostWrite = 1'b0;
		hostWrData = 16'h0000;
	end

	// ==========================================================================
	// one transfer of n words; only the first word loads the address
	task automatic xfer(input logic w, input logic [7:0] a, input sns_pkg::sns_word_t d,
			input int n);
		@(posedge clk);
		hostAddrLoad <= 1'b1;
		hostAddr <= a;
		hostRead <= !w;
		hostWrite <= w;
		hostWrData <= d;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			hostAddrLoad <= 1'b0;
			// released lines show the inverse so a stale value cannot pass
			hostAddr <= ~a;
			if (i == n - 1) begin
				hostRead <= 1'b0;
				hostWrite <= 1'b0;
				hostWrData <= ~d;
			end
			#1;
			got[i] = hostRdData;
			gotValid[i] = hostRdValid;
			gotRej = hostWrReject;
		end
	endtask
endmodule

// File: test_sensor_status_event_regs.sv
// self-checking bench of the sensor status register bank
`timescale 1ns/1ps

module test_sensor_status_event_regs;
	localparam logic [63:0] SER = 64'h0000_0000_1234_abcd; // value arbitrary

	logic               clk, rst_n, hostAddrLoad, hostRead, hostWrite, hostRdValid;
	logic               tempUpdate, presUpdate, chipBusy, dspSaturated, hostWrReject;
	logic               bridgeSupplyFault, bridgeCheckFault, comCrcError, cmdWrite;
	logic [7:0]         hostAddr;
	sns_pkg::sns_word_t hostWrData, hostRdData, tempValue, presValue, cmdWord;
	int                 fails, num_checks;

	sns_status_regs #(.SERIAL_NUMBER(SER)) sns_status_regs_i (.clk(clk), .rst_n(rst_n),
		.hostAddrLoad(hostAddrLoad), .hostAddr(hostAddr), .hostRead(hostRead),
		.hostWrite(hostWrite), .hostWrData(hostWrData), .tempUpdate(tempUpdate),
		.tempValue(tempValue), .presUpdate(presUpdate), .presValue(presValue),
		.chipBusy(chipBusy), .dspSaturated(dspSaturated),
		.bridgeSupplyFault(bridgeSupplyFault), .bridgeCheckFault(bridgeCheckFault),
		.comCrcError(comCrcError), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
		.hostWrReject(hostWrReject), .cmdWrite(cmdWrite), .cmdWord(cmdWord));

	sns_host_model sns_host_model_i (.clk(clk), .hostAddrLoad(hostAddrLoad),
		.hostAddr(hostAddr), .hostRead(hostRead), .hostWrite(hostWrite),
		.hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
		.hostWrReject(hostWrReject));

	// ==========================================================================
	// compares and bus helpers
	task automatic chkWord(input sns_pkg::sns_word_t g, input sns_pkg::sns_word_t e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t word %h expected %h", $time, g, e);
		end
	endtask

	task automatic chkBit(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t flag %b expected %b", $time, g, e);
		end
	endtask

	task automatic rd(input logic [7:0] a, input sns_pkg::sns_word_t e);
		sns_host_model_i.xfer(1'b0, a, 16'h0000, 1);
		chkBit(sns_host_model_i.gotValid[0], 1'b1);
		chkWord(sns_host_model_i.got[0], e);
	endtask

	task automatic wr(input logic [7:0] a, input sns_pkg::sns_word_t d, input logic rej);
		sns_host_model_i.xfer(1'b1, a, d, 1);
		chkBit(sns_host_model_i.gotRej, rej);
	endtask

	task automatic burst(input sns_pkg::sns_word_t s);
		sns_host_model_i.xfer(1'b0, 8'h2e, 16'h0000, 3);
		chkWord(sns_host_model_i.got[0], tempValue);
		chkWord(sns_host_model_i.got[1], presValue);
		chkWord(sns_host_model_i.got[2], s);
		chkBit(sns_host_model_i.gotValid[2], 1'b1);
	endtask

	// mask order: temperature, pressure, supply, check, crc
	task automatic pulse(input logic [4:0] m);
		@(posedge clk);
		{tempUpdate, presUpdate, bridgeSupplyFault, bridgeCheckFault, comCrcError} <= m;
		@(posedge clk);
		{tempUpdate, presUpdate, bridgeSupplyFault, bridgeCheckFault, comCrcError} <= 5'h00;
	endtask

	task automatic level(input logic busy, input logic sat);
		@(posedge clk);
		chipBusy <= busy;
		dspSaturated <= sat;
		repeat (2) @(posedge clk);
	endtask

	// ==========================================================================
	// scenarios
	task automatic scnReset();
		rd(8'h36, 16'h0000);
		rd(8'h32, 16'h0000);
		level(1'b0, 1'b0);
		rd(8'h36, 16'h0001);
		rd(8'h32, 16'h0001);
	endtask

	task automatic scnUpdate();
		tempValue <= 16'h7df2;
		presValue <= 16'h82ea;
		pulse(5'h18);
		rd(8'h36, 16'h0019);
		burst(16'h0019);
		rd(8'h36, 16'h0001);
		rd(8'h32, 16'h0019);
		burst(16'h0001);
	endtask

	task automatic scnMissed();
		pulse(5'h18);
		pulse(5'h18);
		rd(8'h36, 16'hc019);
		rd(8'h32, 16'hc001);
		wr(8'h32, 16'hffff, 1'b1);
		rd(8'h36, 16'hc019);
		wr(8'h36, 16'h8008, 1'b0);
		rd(8'h36, 16'h4011);
		wr(8'h36, 16'hffff, 1'b0);
		rd(8'h36, 16'h0001);
	endtask

	task automatic scnFaults();
		pulse(5'h07);
		rd(8'h36, 16'h0981);
		level(1'b0, 1'b1);
		wr(8'h36, 16'h0401, 1'b0);
		rd(8'h36, 16'h0d81);
		rd(8'h32, 16'h0d81);
		level(1'b1, 1'b0);
		rd(8'h36, 16'h0980);
		// clear and a fresh supply fault land on the same edge
		fork
			wr(8'h36, 16'hffff, 1'b0);
			pulse(5'h04);
		join
		rd(8'h36, 16'h0080);
	endtask

	task automatic scnSerial();
		rd(8'h50, SER[15:0]);
		rd(8'h52, SER[31:16]);
		wr(8'h50, 16'h0000, 1'b1);
		rd(8'h50, SER[15:0]);
		rd(8'h60, 16'h0000);
		wr(8'h22, 16'h6c32, 1'b0);
		chkBit(cmdWrite, 1'b1);
		chkWord(cmdWord, 16'h6c32);
	endtask

	task automatic results();
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ==========================================================================
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		results();
	end

	initial begin
		fails = 0;
		num_checks = 0;
		rst_n = 1'b0;
		{tempUpdate, presUpdate, bridgeSupplyFault, bridgeCheckFault, comCrcError} = 5'h00;
		chipBusy = 1'b1;
		dspSaturated = 1'b0;
		tempValue = 16'h0000;
		presValue = 16'h0000;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		scnReset();
		scnUpdate();
		scnMissed();
		scnFaults();
		scnSerial();
		results();
	end
endmodule
